// ===== common/tbpeq_pkg.sv
// Shared constants for the transmit packet-end qualifier
package tbpeq_pkg;
    // Segment geometry
    localparam int SEG_NUM = 4;
    localparam int DATA_W = 128;
    localparam int MTY_W = 4;
    localparam int BYTE_NUM = 16;
    // Error code control word, one /E/ character in every byte lane
    localparam logic [127:0] ERR_CODE_WORD = {16{8'hFE}};
    // Empty-count bits kept when a packet ends in error
    localparam logic [3:0] MTY_ERR_KEEP = 4'h8;
    // Per-segment record layout inside a FIFO word
    localparam int REC_DATA_LSB = 0;
    localparam int REC_SOP = 128;
    localparam int REC_EOP = 129;
    localparam int REC_ERR = 130;
    localparam int REC_EN = 131;
    localparam int REC_MTY_LSB = 132;
    localparam int REC_W = 136;
    localparam int FIFO_W = REC_W * SEG_NUM;
    // FIFO depth in cycle words
    localparam int FIFO_DEPTH = 8;
endpackage

// ===== hdl/tbpeq_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module tbpeq_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Write side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    // Read side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    // Honest full and empty straight from the fill count
    assign wr_ready = (count_q != (AW+1)'(DEPTH));
    assign rd_valid = (count_q != '0);
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;
    // Head word comes out of the storage flops
    assign rd_data = mem_q[rd_ptr_q];

    // Pointer and count update, wrapping at the depth
    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (push) begin
            wr_ptr_d = (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
        end
        if (pop) begin
            rd_ptr_d = (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
        end
    end

    // Storage needs no reset; only counted words are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data;
        end
    end

    fifo_bound_a: assert property (@(posedge core_clk) disable iff (srst)
        count_q <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule

// ===== hdl/tbpeq_seg_qual.sv
// Qualifies one segment's inputs under its enable and end flags
`timescale 1ns/10ps
module tbpeq_seg_qual (
    // Raw segment inputs from user logic
    input wire logic en,
    input wire logic sop,
    input wire logic eop,
    input wire logic err,
    input wire logic [3:0] mty,
    input wire logic [127:0] data,
    // Qualified record
    output logic [tbpeq_pkg::REC_W-1:0] rec
);
    logic q_eop, q_err;
    logic [3:0] q_mty;
    logic [127:0] q_data;

    // Disabled segment contributes nothing at all
    always_comb begin
        q_eop = en && eop;
        q_err = q_eop && err;
        q_mty = '0;
        if (q_eop) begin
            q_mty = mty;
            if (q_err) begin
                q_mty = mty & tbpeq_pkg::MTY_ERR_KEEP;
            end
        end
        q_data = en ? data : '0;
        if (q_err) begin
            q_data = tbpeq_pkg::ERR_CODE_WORD;
        end
        rec = {q_mty, en, q_err, q_eop, en && sop, q_data};
    end
endmodule

// ===== hdl/tbpeq_top.sv
// Transmit segmented packet-end qualifier with an 8-word FIFO
//
// What this block does
// - End flag sampled only when segment enabled
// - Error sampled only with enable and end
// - Errored packet's last word becomes error code
// - No frame check for an errored packet
// - Empty count drops that many trailing bytes
// - Empty count sampled only with enable, end
// - On error, empty count low bits zero
// - Four independent segments on one clock
// - Disabled segment's signals all ignored
// - Data captured when segment enabled and in_ready high, except errored end word
// - Under-run raises underflow, sends error blocks
`timescale 1ns/10ps
module tbpeq_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Segment inputs from user transmit logic
    input wire logic [3:0] seg_valid_enable,
    input wire logic [3:0] seg_start_of_packet,
    input wire logic [3:0] seg_end_of_packet,
    input wire logic [3:0] seg_packet_error,
    input wire logic [3:0][3:0] seg_empty_byte_count,
    input wire logic [3:0][127:0] seg_data_word,
    output logic in_ready,
    // Qualified output toward the encoder
    output logic out_valid,
    input wire logic out_ready,
    output logic [3:0] out_seg_enable,
    output logic [3:0] out_seg_sop,
    output logic [3:0] out_seg_eop,
    output logic [3:0] out_seg_err,
    output logic [3:0][3:0] out_seg_empty,
    output logic [3:0][15:0] out_seg_byte_mask,
    output logic [3:0][127:0] out_seg_data,
    output logic [3:0] out_fcs_check,
    output logic out_ctrl_error,
    // Status
    output logic tx_underflow_flag
);
    localparam int NS = tbpeq_pkg::SEG_NUM;
    localparam int RW = tbpeq_pkg::REC_W;

    logic [tbpeq_pkg::FIFO_W-1:0] fifo_wr_data, fifo_rd_data;
    logic fifo_wr_valid, fifo_rd_valid, fifo_rd_ready;

    // One qualifier per segment, packed in ascending segment order
    for (genvar g = 0; g < NS; g++) begin : g_seg
        tbpeq_seg_qual u_qual (
            .en(seg_valid_enable[g]),
            .sop(seg_start_of_packet[g]),
            .eop(seg_end_of_packet[g]),
            .err(seg_packet_error[g]),
            .mty(seg_empty_byte_count[g]),
            .data(seg_data_word[g]),
            .rec(fifo_wr_data[g*RW +: RW])
        );
    end

    // Only cycles with an enabled segment enter the FIFO
    assign fifo_wr_valid = |seg_valid_enable;

    tbpeq_fifo #(
        .WIDTH(tbpeq_pkg::FIFO_W),
        .DEPTH(tbpeq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .wr_valid(fifo_wr_valid),
        .wr_ready(in_ready),
        .wr_data(fifo_wr_data),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_rd_ready),
        .rd_data(fifo_rd_data)
    );

    // Output stage state
    logic out_valid_q, out_valid_d;
    logic [3:0] en_q, en_d, sop_q, sop_d, eop_q, eop_d, err_q, err_d;
    logic [3:0] fcs_q, fcs_d;
    logic [3:0][3:0] mty_q, mty_d;
    logic [3:0][15:0] mask_q, mask_d;
    logic [3:0][127:0] data_q, data_d;
    logic ctrl_err_q, ctrl_err_d, unf_q, unf_d;
    logic pkt_open_q, pkt_open_d, corrupt_q, corrupt_d;
    logic load;

    // Stage refills when empty or when the consumer takes it
    assign load = !out_valid_q || out_ready;
    assign fifo_rd_ready = load;

    // Next output word; packet state walks segments 0 to 3
    always_comb begin
        logic [RW-1:0] r;
        logic open_v, corrupt_v;
        r = '0;
        open_v = pkt_open_q;
        corrupt_v = corrupt_q;
        out_valid_d = out_valid_q;
        en_d = en_q;
        sop_d = sop_q;
        eop_d = eop_q;
        err_d = err_q;
        fcs_d = fcs_q;
        mty_d = mty_q;
        mask_d = mask_q;
        data_d = data_q;
        ctrl_err_d = ctrl_err_q;
        unf_d = unf_q;
        if (load && fifo_rd_valid) begin
            out_valid_d = 1'b1;
            ctrl_err_d = 1'b0;
            unf_d = 1'b0;
            for (int s = 0; s < NS; s++) begin
                r = fifo_rd_data[s*RW +: RW];
                en_d[s] = r[tbpeq_pkg::REC_EN];
                sop_d[s] = r[tbpeq_pkg::REC_SOP];
                eop_d[s] = r[tbpeq_pkg::REC_EOP];
                err_d[s] = r[tbpeq_pkg::REC_ERR];
                mty_d[s] = r[tbpeq_pkg::REC_MTY_LSB +: 4];
                data_d[s] = r[tbpeq_pkg::REC_DATA_LSB +: 128];
                if (sop_d[s]) begin
                    open_v = 1'b1;
                    corrupt_v = 1'b0;
                end
                // An under-run packet ends as errored
                if (eop_d[s] && corrupt_v && !err_d[s]) begin
                    err_d[s] = 1'b1;
                    mty_d[s] = mty_d[s] & tbpeq_pkg::MTY_ERR_KEEP;
                    data_d[s] = tbpeq_pkg::ERR_CODE_WORD;
                end
                // Frame check only for a packet ending clean
                fcs_d[s] = eop_d[s] && !err_d[s];
                if (eop_d[s]) begin
                    open_v = 1'b0;
                    corrupt_v = 1'b0;
                end
                // Trailing empty bytes sit in the low lanes
                for (int b = 0; b < tbpeq_pkg::BYTE_NUM; b++) begin
                    mask_d[s][b] = en_d[s] &&
                        (!eop_d[s] || (5'(b) >= {1'b0, mty_d[s]}));
                end
            end
        end else if (load) begin
            // Nothing queued mid-packet is an under-run
            out_valid_d = pkt_open_q;
            ctrl_err_d = pkt_open_q;
            unf_d = pkt_open_q;
            en_d = '0;
            sop_d = '0;
            eop_d = '0;
            err_d = '0;
            fcs_d = '0;
            mty_d = '0;
            mask_d = '0;
            for (int s = 0; s < NS; s++) begin
                data_d[s] = pkt_open_q ? tbpeq_pkg::ERR_CODE_WORD : '0;
            end
            if (pkt_open_q) begin
                corrupt_v = 1'b1;
            end
        end
        pkt_open_d = open_v;
        corrupt_d = corrupt_v;
    end

    // Output stage registers; every output except in_ready is a flop
    always_ff @(posedge core_clk) begin
        if (srst) begin
            out_valid_q <= 1'b0;
            en_q <= '0;
            sop_q <= '0;
            eop_q <= '0;
            err_q <= '0;
            fcs_q <= '0;
            mty_q <= '0;
            mask_q <= '0;
            data_q <= '0;
            ctrl_err_q <= 1'b0;
            unf_q <= 1'b0;
            pkt_open_q <= 1'b0;
            corrupt_q <= 1'b0;
        end else begin
            out_valid_q <= out_valid_d;
            en_q <= en_d;
            sop_q <= sop_d;
            eop_q <= eop_d;
            err_q <= err_d;
            fcs_q <= fcs_d;
            mty_q <= mty_d;
            mask_q <= mask_d;
            data_q <= data_d;
            ctrl_err_q <= ctrl_err_d;
            unf_q <= unf_d;
            pkt_open_q <= pkt_open_d;
            corrupt_q <= corrupt_d;
        end
    end

    assign out_valid = out_valid_q;
    assign out_seg_enable = en_q;
    assign out_seg_sop = sop_q;
    assign out_seg_eop = eop_q;
    assign out_seg_err = err_q;
    assign out_seg_empty = mty_q;
    assign out_seg_byte_mask = mask_q;
    assign out_seg_data = data_q;
    assign out_fcs_check = fcs_q;
    assign out_ctrl_error = ctrl_err_q;
    assign tx_underflow_flag = unf_q;

    // Checks on the qualified stream
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_open_starve;
        pkt_open_q && load && !fifo_rd_valid;
    endsequence

    sequence s_err_block;
        tx_underflow_flag && out_ctrl_error && out_valid &&
            (out_seg_enable == 4'h0);
    endsequence

    eop_needs_en_a: assert property (
        out_valid |-> ((out_seg_eop & ~out_seg_enable) == 4'h0))
        else $error("end flag on disabled segment");

    err_needs_eop_a: assert property (
        out_valid |-> ((out_seg_err & ~out_seg_eop) == 4'h0))
        else $error("error flag without end flag");

    mty_needs_eop_a: assert property (
        out_valid |-> ((out_seg_empty[0] == 4'h0) || out_seg_eop[0]))
        else $error("empty count outside end transfer");

    mty_err_zero_a: assert property (
        out_valid && out_seg_err[1] |-> out_seg_empty[1][2:0] == 3'h0)
        else $error("empty low bits kept on error");

    err_code_word_a: assert property (
        out_valid && out_seg_err[2] |->
            out_seg_data[2] == tbpeq_pkg::ERR_CODE_WORD)
        else $error("errored word not replaced");

    fcs_gate_a: assert property (
        out_valid |-> out_fcs_check == (out_seg_eop & ~out_seg_err))
        else $error("frame check on errored packet");

    ignore_disabled_a: assert property (
        !seg_valid_enable[3] |-> fifo_wr_data[3*RW +: RW] == '0)
        else $error("disabled segment leaked");

    capture_push_a: assert property (
        fifo_wr_valid && in_ready |=> fifo_rd_valid || out_valid)
        else $error("enabled data not captured");

    underflow_seq_a: assert property (
        s_open_starve |=> s_err_block)
        else $error("under-run not flagged");

    mask_tail_a: assert property (
        out_valid && out_seg_eop[0] && out_seg_empty[0] == 4'h1 |->
            out_seg_byte_mask[0] == 16'hFFFE)
        else $error("empty byte not dropped");

    // Junk start flags on idle lanes must never reach the encoder
    sop_needs_en_a: assert property (
        out_valid |-> ((out_seg_sop & ~out_seg_enable) == 4'h0))
        else $error("start flag on disabled segment");

    // An idle lane offers no bytes, whatever its data lines carried
    mask_disabled_a: assert property (
        out_valid && !out_seg_enable[3] |->
            out_seg_byte_mask[3] == 16'h0000)
        else $error("bytes valid on disabled segment");
endmodule

// ===== test/tbpeq_user_model.sv
// Behavioural model of the user logic feeding packet segments
`timescale 1ns/10ps
module tbpeq_user_model (
    // Clock and flow control
    input wire logic core_clk,
    input wire logic in_ready,
    // Segment lines toward the block
    output logic [3:0] en,
    output logic [3:0] sop,
    output logic [3:0] eop,
    output logic [3:0] err,
    output logic [3:0][3:0] mty,
    output logic [3:0][127:0] dat
);
    logic [7:0] junk = 8'h00;

    // Drive one cycle word, hold it until taken or the bound runs out
    task automatic send(input logic [3:0] e, input logic [3:0] s,
        input logic [3:0] p, input logic [3:0] r,
        input logic [3:0][3:0] m, input logic [3:0][127:0] d,
        input int bound, output bit ok);
        ok = 1'b0;
        junk = junk + 8'h01;
        // Idle segments carry a changing pattern, never the last value
        for (int i = 0; i < 4; i++) begin
            en[i] = e[i];
            sop[i] = e[i] ? s[i] : junk[0];
            eop[i] = e[i] ? p[i] : junk[1];
            err[i] = e[i] ? (p[i] & r[i]) : junk[2];
            mty[i] = (e[i] & p[i]) ? m[i] : junk[3:0];
            dat[i] = e[i] ? d[i] : {16{junk}};
        end
        for (int n = 0; n < bound && !ok; n++) begin
            ok = (in_ready === 1'b1);
            @(posedge core_clk);
            #1;
        end
    endtask
endmodule

// ===== test/tbpeq_top_test.sv
// Self-checking testbench for the transmit packet-end qualifier
`timescale 1ns/10ps
module tbpeq_top_test;
    logic core_clk = 1'b0;
    logic srst;
    logic out_ready;
    logic in_ready, out_valid, out_ctrl_error, tx_underflow_flag;
    logic [3:0] en, sop, eop, err, o_en, o_sop, o_eop, o_err, o_fcs;
    logic [3:0][3:0] mty, o_mty;
    logic [3:0][127:0] dat, o_dat;
    logic [3:0][15:0] o_mask;
    // Snapshot of the last word taken
    logic [3:0] w_en, w_sop, w_eop, w_err, w_fcs;
    logic [3:0][3:0] w_mty;
    logic [3:0][15:0] w_mask;
    logic [3:0][127:0] w_dat;
    logic w_ce, w_uf;
    int miscompares = 0;
    int cmp_count = 0;

    // Free-running 100 MHz clock
    always #5 core_clk = ~core_clk;

    tbpeq_user_model u (.core_clk(core_clk), .in_ready(in_ready),
        .en(en), .sop(sop), .eop(eop), .err(err), .mty(mty), .dat(dat));

    tbpeq_top dut (.core_clk(core_clk), .srst(srst),
        .seg_valid_enable(en), .seg_start_of_packet(sop),
        .seg_end_of_packet(eop), .seg_packet_error(err),
        .seg_empty_byte_count(mty), .seg_data_word(dat),
        .in_ready(in_ready), .out_valid(out_valid),
        .out_ready(out_ready), .out_seg_enable(o_en),
        .out_seg_sop(o_sop), .out_seg_eop(o_eop), .out_seg_err(o_err),
        .out_seg_empty(o_mty), .out_seg_byte_mask(o_mask),
        .out_seg_data(o_dat), .out_fcs_check(o_fcs),
        .out_ctrl_error(out_ctrl_error),
        .tx_underflow_flag(tx_underflow_flag));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [127:0] pd(input int b, input int s);
        return {8{b[7:0], s[7:0]}};
    endfunction

    // Offer one word; a refusal past the bound ends the run
    task automatic go(input logic [3:0] e, input logic [3:0] s,
        input logic [3:0] p, input logic [3:0] r,
        input logic [3:0][3:0] m, input logic [3:0][127:0] d);
        bit ok;
        u.send(e, s, p, r, m, d, 20, ok);
        if (!ok) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    task automatic idle();
        bit ok;
        u.send(4'h0, 4'h0, 4'h0, 4'h0, '0, '0, 0, ok);
    endtask

    // Wait a bounded time for a word, snapshot it, let it be taken
    task automatic take();
        bit got;
        got = 1'b0;
        for (int n = 0; n < 20 && !got; n++) begin
            if (out_valid === 1'b1) begin
                got = 1'b1;
                {w_en, w_sop, w_eop, w_err, w_fcs} =
                    {o_en, o_sop, o_eop, o_err, o_fcs};
                {w_mty, w_mask, w_dat} = {o_mty, o_mask, o_dat};
                {w_ce, w_uf} = {out_ctrl_error, tx_underflow_flag};
            end
            @(posedge core_clk);
            #1;
        end
        if (!got) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // Whole packet over four segments, ending with five empty bytes
    task automatic t_full();
        go(4'hF, 4'h1, 4'h8, 4'h0, {4'h5, 4'h3, 4'h3, 4'h3},
            {pd(1, 3), pd(1, 2), pd(1, 1), pd(1, 0)});
        idle();
        take();
        chk(w_en, 4'hF);
        chk(w_eop, 4'h8);
        chk(w_mty, 16'h5000);
        chk(w_mask[3], 16'hFFE0);
        chk(w_dat[2], pd(1, 2));
        chk(w_fcs, 4'h8);
        $display("test full packet done");
    endtask

    // Errored packet ends in segment 1, clean one follows in the same word
    task automatic t_err();
        go(4'hF, 4'h5, 4'hA, 4'h2, {4'h0, 4'h0, 4'hF, 4'h0},
            {pd(2, 3), pd(2, 2), pd(2, 1), pd(2, 0)});
        idle();
        take();
        chk(w_err, 4'h2);
        chk(w_dat[1], tbpeq_pkg::ERR_CODE_WORD);
        chk(w_mty, 16'h0080);
        chk(w_mask[1], 16'hFF00);
        chk(w_fcs, 4'h8);
        chk(w_sop, 4'h5);
        $display("test errored packet done");
    endtask

    // Disabled segments carry junk that must be ignored
    task automatic t_dis();
        go(4'h5, 4'h5, 4'h5, 4'h0, '0,
            {pd(3, 3), pd(3, 2), pd(3, 1), pd(3, 0)});
        idle();
        take();
        chk(w_en, 4'h5);
        chk({w_sop, w_eop, w_err}, 12'h550);
        chk(w_dat[1] | w_dat[3], 128'h0);
        chk(w_mask[3], 16'h0000);
        chk(w_dat[2], pd(3, 2));
        $display("test disabled segments done");
    endtask

    // Stall the far side until the buffer refuses, then drain in order
    task automatic t_fill();
        bit ok;
        int acc;
        ok = 1'b1;
        acc = 0;
        out_ready = 1'b0;
        for (int i = 0; i < 12 && ok; i++) begin
            u.send(4'h1, 4'h1, 4'h1, 4'h0, '0,
                {{3{128'h0}}, pd(i, 0)}, 1, ok);
            if (ok) begin
                acc++;
            end
        end
        idle();
        chk(acc, 9);
        chk(in_ready, 1'b0);
        out_ready = 1'b1;
        for (int i = 0; i < acc; i++) begin
            take();
            chk(w_dat[0], pd(i, 0));
        end
        chk(out_valid, 1'b0);
        $display("test buffer fill done");
    endtask

    // Starve an open packet, then close it late
    task automatic t_unf();
        go(4'h1, 4'h1, 4'h0, 4'h0, '0, {{3{128'h0}}, pd(7, 0)});
        idle();
        take();
        chk(w_uf, 1'b0);
        take();
        chk({w_ce, w_uf, w_en}, 6'h30);
        go(4'h1, 4'h0, 4'h1, 4'h0, {12'h0, 4'hB}, {{3{128'h0}}, pd(8, 0)});
        idle();
        for (int n = 0; n < 20 && w_eop[0] !== 1'b1; n++) begin
            take();
        end
        chk(w_err[0], 1'b1);
        chk(w_dat[0], tbpeq_pkg::ERR_CODE_WORD);
        chk(w_mty, 16'h0008);
        chk(w_fcs, 4'h0);
        $display("test underflow done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        srst = 1'b1;
        out_ready = 1'b1;
        // Segment lines are released at time zero, from this process only
        idle();
        repeat (20) @(posedge core_clk);
        #1;
        srst = 1'b0;
        @(posedge core_clk);
        #1;
        t_full();
        t_err();
        t_dis();
        t_fill();
        t_unf();
        report_and_stop();
    end
endmodule
